// >>> pkg/tsm_pkg.sv
/*
 * Constants for the first-timer split mode and run/flag control register.
 * Assumes an 8-bit special-function bus with byte and single-bit writes.
 */
package tsm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] TSM_CTRL_ADDR  = 8'h88;
  localparam logic [7:0] TSM_CTRL_RESET = 8'h00;
  localparam logic [4:0] TSM_CTRL_BITBASE = 5'h11; // 0x88 >> 3

  // ----------------------------------------------------------------
  // Field positions of timer_run_flag_control
  // ----------------------------------------------------------------
  localparam int TSM_TF1_BIT = 7;
  localparam int TSM_TR1_BIT = 6;
  localparam int TSM_TF0_BIT = 5;
  localparam int TSM_TR0_BIT = 4;
  localparam int TSM_IE1_BIT = 3;
  localparam int TSM_IT1_BIT = 2;
  localparam int TSM_IE0_BIT = 1;
  localparam int TSM_IT0_BIT = 0;

  // ----------------------------------------------------------------
  // Count register select for direct loads
  // ----------------------------------------------------------------
  localparam logic [1:0] TSM_SEL_T0_LOW  = 2'h0;
  localparam logic [1:0] TSM_SEL_T0_HIGH = 2'h1;
  localparam logic [1:0] TSM_SEL_T1_LOW  = 2'h2;
  localparam logic [1:0] TSM_SEL_T1_HIGH = 2'h3;

  // ----------------------------------------------------------------
  // Timer modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TSM_MODE_13BIT  = 2'b00,
    TSM_MODE_16BIT  = 2'b01,
    TSM_MODE_RELOAD = 2'b10,
    TSM_MODE_SPLIT  = 2'b11
  } tsm_mode_t;

endpackage

// >>> rtl/tsm_timer_split.sv
/*
 * First and second counter/timer with split mode and the shared run and
 * flag control register. Assumes the CPU drives the register port and the
 * interrupt acknowledges on ref_clk_i; pins are asynchronous.
 */
module tsm_timer_split
  import tsm_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       bit_wr_i,
  input  wire logic [7:0] bit_addr_i,
  input  wire logic       bit_val_i,
  input  wire logic       cnt_wr_i,
  input  wire logic [1:0] cnt_sel_i,
  input  wire logic [1:0] t0_mode_i,
  input  wire logic [1:0] t1_mode_i,
  input  wire logic       first_counter_select_i,
  input  wire logic       first_timer_gate_i,
  input  wire logic       second_counter_select_i,
  input  wire logic       second_timer_gate_i,
  input  wire logic       t0_sysclk_sel_i,
  input  wire logic       t1_sysclk_sel_i,
  input  wire logic       prescale_tick_i,
  input  wire logic       t0_count_pin_i,
  input  wire logic       t1_count_pin_i,
  input  wire logic       first_ext_irq_input_i,
  input  wire logic       second_ext_irq_input_i,
  input  wire logic       t0_irq_ack_i,
  input  wire logic       t1_irq_ack_i,
  input  wire logic       ext0_irq_ack_i,
  input  wire logic       ext1_irq_ack_i,
  output logic      [7:0] sfr_rdata_o,
  output logic      [7:0] timer_run_flag_control_o,
  output logic      [7:0] t0_low_count_byte_o,
  output logic      [7:0] t0_high_count_byte_o,
  output logic     [15:0] t1_count_o,
  output logic            t1_overflow_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers: t0 pin, t1 pin, first_ext_irq_input, second_ext_irq_input
  // ----------------------------------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] sy1_q;
  logic [3:0] sy2_q;
  logic [3:0] sy3_q;
  assign pin_raw = {second_ext_irq_input_i, first_ext_irq_input_i,
                    t1_count_pin_i, t0_count_pin_i};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          sy1_q[gi] <= 1'b0;
          sy2_q[gi] <= 1'b0;
          sy3_q[gi] <= 1'b0;
        end else begin
          sy1_q[gi] <= pin_raw[gi];
          sy2_q[gi] <= sy1_q[gi];
          sy3_q[gi] <= sy2_q[gi];
        end
      end
    end
  endgenerate

  logic t0_pin_fall;
  logic t1_pin_fall;
  logic first_ext_irq_input_act;
  logic second_ext_irq_input_act;
  logic first_ext_irq_input_rise;
  logic second_ext_irq_input_rise;
  assign t0_pin_fall = sy3_q[0] & ~sy2_q[0];
  assign t1_pin_fall = sy3_q[1] & ~sy2_q[1];
  assign first_ext_irq_input_act    = sy2_q[2];
  assign second_ext_irq_input_act    = sy2_q[3];
  assign first_ext_irq_input_rise   = sy2_q[2] & ~sy3_q[2];
  assign second_ext_irq_input_rise   = sy2_q[3] & ~sy3_q[3];

  // ----------------------------------------------------------------
  // Count step: returns {overflow, high, low}
  // ----------------------------------------------------------------
  function automatic logic [16:0] tsm_step(input logic [1:0] mode,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0]  s8;
    s13 = 14'({hi, lo[4:0]}) + 14'h0001;
    s16 = 17'({hi, lo}) + 17'h0_0001;
    s8  = 9'(lo) + 9'h001;
    case (mode)
      TSM_MODE_13BIT:  tsm_step = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
      TSM_MODE_16BIT:  tsm_step = s16;
      TSM_MODE_RELOAD: tsm_step = {s8[8], hi, s8[8] ? hi : s8[7:0]};
      default:         tsm_step = {s8[8], hi, s8[7:0]};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Control register and counters
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_q, ctrl_d;
  logic [7:0]  tl0_q, tl0_d, th0_q, th0_d;
  logic [7:0]  tl1_q, tl1_d, th1_q, th1_d;
  logic        t1_ovf_q, t1_ovf_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        split, tr0, tr1;
  logic        tick0, tick1, run0, run1, hi_run;
  logic        t0_ovf, t1_ovf, hi_ovf;
  logic [16:0] s0, s1;
  logic [8:0]  hs;
  logic [7:0]  set_v, clr_v;
  logic        byte_wr, bit_hit;

  assign split = (t0_mode_i == TSM_MODE_SPLIT);
  assign tr0   = ctrl_q[TSM_TR0_BIT];
  assign tr1   = ctrl_q[TSM_TR1_BIT];
  assign byte_wr = sfr_wr_i & (sfr_addr_i == TSM_CTRL_ADDR);
  assign bit_hit = bit_wr_i & (bit_addr_i[7:3] == TSM_CTRL_BITBASE);

  always_comb begin
    // Clock path or external pin for the low byte / first timer
    tick0 = first_counter_select_i ? t0_pin_fall
          : (t0_sysclk_sel_i ? 1'b1 : prescale_tick_i);
    run0  = tr0 & (~first_timer_gate_i | first_ext_irq_input_act);
    // Split second timer: internal clock only, run by its mode
    tick1 = (~split & second_counter_select_i) ? t1_pin_fall
          : (t1_sysclk_sel_i ? 1'b1 : prescale_tick_i);
    run1  = (t1_mode_i != TSM_MODE_SPLIT)
          & (split | (tr1 & (~second_timer_gate_i | second_ext_irq_input_act)));
    hi_run = split & tr1 & (t0_sysclk_sel_i ? 1'b1 : prescale_tick_i);
    s0 = tsm_step(t0_mode_i, tl0_q, th0_q);
    s1 = tsm_step(t1_mode_i, tl1_q, th1_q);
    hs = 9'(th0_q) + 9'h001;
    t0_ovf = run0 & tick0 & s0[16];
    t1_ovf = run1 & tick1 & s1[16];
    hi_ovf = hi_run & hs[8];
    tl0_d = tl0_q;
    th0_d = th0_q;
    tl1_d = tl1_q;
    th1_d = th1_q;
    if (run0 & tick0) begin
      tl0_d = s0[7:0];
      if (!split) begin
        th0_d = s0[15:8];
      end
    end
    if (hi_run) begin
      th0_d = hs[7:0];
    end
    if (run1 & tick1) begin
      tl1_d = s1[7:0];
      th1_d = s1[15:8];
    end
    if (cnt_wr_i) begin
      case (cnt_sel_i)
        TSM_SEL_T0_LOW:  tl0_d = sfr_wdata_i;
        TSM_SEL_T0_HIGH: th0_d = sfr_wdata_i;
        TSM_SEL_T1_LOW:  tl1_d = sfr_wdata_i;
        default:         th1_d = sfr_wdata_i;
      endcase
    end
    t1_ovf_d = t1_ovf;
    // Hardware sets; they win over any clear in the same cycle
    set_v = 8'h00;
    set_v[TSM_TF0_BIT] = t0_ovf;
    set_v[TSM_TF1_BIT] = split ? hi_ovf : t1_ovf;
    set_v[TSM_IE1_BIT] = ctrl_q[TSM_IT1_BIT] ? second_ext_irq_input_rise : second_ext_irq_input_act;
    set_v[TSM_IE0_BIT] = ctrl_q[TSM_IT0_BIT] ? first_ext_irq_input_rise : first_ext_irq_input_act;
    clr_v = 8'h00;
    clr_v[TSM_TF0_BIT] = t0_irq_ack_i;
    clr_v[TSM_TF1_BIT] = t1_irq_ack_i;
    clr_v[TSM_IE1_BIT] = ext1_irq_ack_i & ctrl_q[TSM_IT1_BIT];
    clr_v[TSM_IE0_BIT] = ext0_irq_ack_i & ctrl_q[TSM_IT0_BIT];
    ctrl_d = ctrl_q & ~clr_v;
    if (byte_wr) begin
      ctrl_d = sfr_wdata_i;
    end else if (bit_hit) begin
      ctrl_d[bit_addr_i[2:0]] = bit_val_i;
    end
    ctrl_d = ctrl_d | set_v;
    rdata_d = (sfr_addr_i == TSM_CTRL_ADDR) ? ctrl_q : 8'h00;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q   <= TSM_CTRL_RESET;
      tl0_q    <= 8'h00;
      th0_q    <= 8'h00;
      tl1_q    <= 8'h00;
      th1_q    <= 8'h00;
      t1_ovf_q <= 1'b0;
      rdata_q  <= 8'h00;
    end else begin
      ctrl_q   <= ctrl_d;
      tl0_q    <= tl0_d;
      th0_q    <= th0_d;
      tl1_q    <= tl1_d;
      th1_q    <= th1_d;
      t1_ovf_q <= t1_ovf_d;
      rdata_q  <= rdata_d;
    end
  end

  assign sfr_rdata_o              = rdata_q;
  assign timer_run_flag_control_o = ctrl_q;
  assign t0_low_count_byte_o      = tl0_q;
  assign t0_high_count_byte_o     = th0_q;
  assign t1_count_o               = {th1_q, tl1_q};
  assign t1_overflow_o            = t1_ovf_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence second_ext_irq_input_edge_s;
    !sy2_q[3] ##1 sy2_q[3];
  endsequence

  split_low_ovf_a: assert property (
    split && run0 && tick0 && tl0_q == 8'hFF |=> ctrl_q[TSM_TF0_BIT])
    else $error("low byte overflow did not set first flag");
  split_high_hold_a: assert property (
    split && !tr1 && !cnt_wr_i |=> $stable(th0_q))
    else $error("high byte moved without second run bit");
  split_high_ovf_a: assert property (
    hi_run && th0_q == 8'hFF |=> ctrl_q[TSM_TF1_BIT] && th0_q == 8'h00)
    else $error("high byte overflow did not set second flag");
  split_no_t1flag_a: assert property (
    split && !hi_ovf && !ctrl_q[TSM_TF1_BIT] && !byte_wr && !bit_hit
    |=> !ctrl_q[TSM_TF1_BIT])
    else $error("second flag set by second timer in split mode");
  t1_baud_out_a: assert property (
    t1_ovf |=> t1_overflow_o ##1 !t1_overflow_o || $past(t1_ovf))
    else $error("second timer overflow pulse missing");
  t1_mode3_stop_a: assert property (
    t1_mode_i == TSM_MODE_SPLIT && !cnt_wr_i |=> $stable(t1_count_o))
    else $error("second timer counted in mode 3");
  t0_run_off_a: assert property (
    !tr0 && !split && !cnt_wr_i |=> $stable({th0_q, tl0_q}))
    else $error("first timer counted while run bit clear");
  gate_block_a: assert property (
    first_timer_gate_i && !first_ext_irq_input_act && !split && !cnt_wr_i
    |=> $stable({th0_q, tl0_q}))
    else $error("first timer counted while gated off");
  edge_irq_a: assert property (
    ctrl_q[TSM_IT1_BIT] && !byte_wr ##0 second_ext_irq_input_edge_s |=> ctrl_q[TSM_IE1_BIT])
    else $error("edge on second input did not set flag");
  level_irq_a: assert property (
    !ctrl_q[TSM_IT1_BIT] && second_ext_irq_input_act |=> ctrl_q[TSM_IE1_BIT])
    else $error("active level did not set second input flag");
  ack_clear_a: assert property (
    t0_irq_ack_i && !t0_ovf && !byte_wr && !bit_hit
    |=> !ctrl_q[TSM_TF0_BIT])
    else $error("first flag not cleared on vectoring");
  bit_write_a: assert property (
    bit_hit && !byte_wr && bit_addr_i[2:0] == 3'h4 && set_v == 8'h00
    && clr_v == 8'h00 |=> tr0 == $past(bit_val_i)
    && ctrl_q[7:5] == $past(ctrl_q[7:5]) && ctrl_q[3:0] == $past(ctrl_q[3:0]))
    else $error("bit write disturbed other control bits");

endmodule

// >>> dv/tsm_timer_split_tb.sv
/*
 * Self-checking bench for the split-mode timer and its control register.
 * Assumes tsm_pkg and tsm_timer_split are compiled first.
 */
module tsm_timer_split_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tsm_pkg::*;

  logic ref_clk_i = 0, rst_n_i = 0, sfr_wr_i = 0, bit_wr_i = 0;
  logic bit_val_i = 0, cnt_wr_i = 0, prescale_tick_i = 0;
  logic [7:0] sfr_addr_i = 0, sfr_wdata_i = 0, bit_addr_i = 0;
  logic [1:0] cnt_sel_i = 0, t0_mode_i = 0, t1_mode_i = 0;
  logic first_counter_select_i = 0, first_timer_gate_i = 0;
  logic second_counter_select_i = 0, second_timer_gate_i = 0;
  logic t0_sysclk_sel_i = 1, t1_sysclk_sel_i = 0;
  logic t0_count_pin_i = 1, t1_count_pin_i = 1;
  logic first_ext_irq_input_i = 0, second_ext_irq_input_i = 0;
  logic t0_irq_ack_i = 0, t1_irq_ack_i = 0;
  logic ext0_irq_ack_i = 0, ext1_irq_ack_i = 0;
  logic [7:0] sfr_rdata_o, timer_run_flag_control_o;
  logic [7:0] t0_low_count_byte_o, t0_high_count_byte_o;
  logic [15:0] t1_count_o;
  logic t1_overflow_o;
  int err_count = 0;
  int samples_checked = 0;

  tsm_timer_split dut (.ref_clk_i, .rst_n_i, .sfr_addr_i, .sfr_wr_i,
    .sfr_wdata_i, .bit_wr_i, .bit_addr_i, .bit_val_i, .cnt_wr_i, .cnt_sel_i,
    .t0_mode_i, .t1_mode_i, .first_counter_select_i, .first_timer_gate_i,
    .second_counter_select_i, .second_timer_gate_i, .t0_sysclk_sel_i,
    .t1_sysclk_sel_i, .prescale_tick_i, .t0_count_pin_i, .t1_count_pin_i,
    .first_ext_irq_input_i, .second_ext_irq_input_i, .t0_irq_ack_i,
    .t1_irq_ack_i, .ext0_irq_ack_i, .ext1_irq_ack_i, .sfr_rdata_o,
    .timer_run_flag_control_o, .t0_low_count_byte_o, .t0_high_count_byte_o,
    .t1_count_o, .t1_overflow_o);

  always #4 ref_clk_i = ~ref_clk_i;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic step(int n = 1);
    repeat (n) @(negedge ref_clk_i);
  endtask

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr_byte(logic [7:0] a, logic [7:0] d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1;
    step();
    sfr_wr_i = 0;
  endtask

  task automatic wr_bit(int idx, logic v);
    bit_addr_i = TSM_CTRL_ADDR + 8'(idx);
    bit_val_i = v;
    bit_wr_i = 1;
    step();
    bit_wr_i = 0;
  endtask

  task automatic ld(logic [1:0] s, logic [7:0] d);
    cnt_sel_i = s;
    sfr_wdata_i = d;
    cnt_wr_i = 1;
    step();
    cnt_wr_i = 0;
  endtask

  task automatic wait_bit(int idx, int lim);
    int n;
    n = 0;
    while (timer_run_flag_control_o[idx] !== 1'b1 && n < lim) begin
      step();
      n++;
    end
    if (n >= lim) begin
      err_count++;
      $display("wrong value at %0t: flag %0d never set", $time, idx);
      summarize();
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    chk(timer_run_flag_control_o, TSM_CTRL_RESET);
    wr_byte(TSM_CTRL_ADDR, 8'h10);
    chk(timer_run_flag_control_o, 8'h10);
    step();
    chk(sfr_rdata_o, 8'h10);
    wr_byte(8'h89, 8'hFF);
    step();
    chk(timer_run_flag_control_o, 8'h10);
    chk(sfr_rdata_o, 8'h00);
    wr_bit(TSM_TR0_BIT, 0);
    wr_bit(TSM_TR1_BIT, 1);
    wr_bit(TSM_IT1_BIT, 1);
    chk(timer_run_flag_control_o, 8'h44);
    wr_byte(TSM_CTRL_ADDR, 8'h00);
    $display("register test done");
  endtask

  task automatic t_split();
    logic [7:0] x;
    t0_mode_i = TSM_MODE_SPLIT;
    ld(TSM_SEL_T0_LOW, 8'hFD);
    ld(TSM_SEL_T0_HIGH, 8'h40);
    wr_bit(TSM_TR0_BIT, 1);
    wait_bit(TSM_TF0_BIT, 10);
    chk(t0_high_count_byte_o, 8'h40);
    chk(timer_run_flag_control_o[TSM_TF1_BIT], 1'b0);
    wr_bit(TSM_TR0_BIT, 0);
    x = t0_low_count_byte_o;
    step(3);
    chk(t0_low_count_byte_o, x);
    wr_bit(TSM_TF0_BIT, 0);
    chk(timer_run_flag_control_o[TSM_TF0_BIT], 1'b0);
    wr_byte(TSM_CTRL_ADDR, 8'h20);
    chk(timer_run_flag_control_o[TSM_TF0_BIT], 1'b1);
    t0_irq_ack_i = 1;
    step();
    t0_irq_ack_i = 0;
    chk(timer_run_flag_control_o[TSM_TF0_BIT], 1'b0);
    ld(TSM_SEL_T0_HIGH, 8'hFE);
    wr_bit(TSM_TR1_BIT, 1);
    wait_bit(TSM_TF1_BIT, 10);
    chk(t0_low_count_byte_o, x);
    chk(timer_run_flag_control_o[TSM_TF0_BIT], 1'b0);
    wr_bit(TSM_TR1_BIT, 0);
    t1_irq_ack_i = 1;
    step();
    t1_irq_ack_i = 0;
    chk(timer_run_flag_control_o[TSM_TF1_BIT], 1'b0);
    $display("split byte test done");
  endtask

  task automatic t_gate_pin();
    first_timer_gate_i = 1;
    ld(TSM_SEL_T0_LOW, 8'h10);
    wr_bit(TSM_TR0_BIT, 1);
    step(5);
    chk(t0_low_count_byte_o, 8'h10);
    first_ext_irq_input_i = 1;
    step(5);
    samples_checked++;
    if (t0_low_count_byte_o === 8'h10) begin
      err_count++;
      $display("wrong value at %0t: gated count did not run", $time);
    end
    first_timer_gate_i = 0;
    first_counter_select_i = 1;
    ld(TSM_SEL_T0_LOW, 8'h20);
    repeat (2) begin
      t0_count_pin_i = 0;
      step(4);
      t0_count_pin_i = 1;
      step(4);
    end
    chk(t0_low_count_byte_o, 8'h22);
    wr_bit(TSM_TR0_BIT, 0);
    first_counter_select_i = 0;
    $display("gate and pin test done");
  endtask

  task automatic t_second();
    int n;
    logic [15:0] x;
    t1_mode_i = TSM_MODE_16BIT;
    ld(TSM_SEL_T1_LOW, 8'hFC);
    ld(TSM_SEL_T1_HIGH, 8'hFF);
    t1_sysclk_sel_i = 1;
    n = 0;
    while (t1_overflow_o !== 1'b1 && n < 10) begin
      step();
      n++;
    end
    chk(16'(n < 10), 16'h0001);
    step(2);
    chk(timer_run_flag_control_o[TSM_TF1_BIT], 1'b0);
    t1_mode_i = TSM_MODE_SPLIT;
    step();
    x = t1_count_o;
    step(3);
    chk(t1_count_o, x);
    $display("second timer test done");
  endtask

  task automatic t_ext();
    wr_bit(TSM_IT1_BIT, 1);
    second_ext_irq_input_i = 1;
    wait_bit(TSM_IE1_BIT, 6);
    ext1_irq_ack_i = 1;
    step();
    ext1_irq_ack_i = 0;
    step(3);
    chk(timer_run_flag_control_o[TSM_IE1_BIT], 1'b0);
    wr_bit(TSM_IT1_BIT, 0);
    wait_bit(TSM_IE1_BIT, 6);
    wr_bit(TSM_IE1_BIT, 0);
    step(2);
    chk(timer_run_flag_control_o[TSM_IE1_BIT], 1'b1);
    second_ext_irq_input_i = 0;
    $display("external flag test done");
  endtask

  initial begin
    #200us;
    err_count++;
    $display("wrong value at %0t: run timed out", $time);
    summarize();
  end

  initial begin
    step(4);
    rst_n_i = 1;
    step();
    t_regs();
    t_split();
    t_gate_pin();
    t_second();
    t_ext();
    summarize();
  end
endmodule
